// [tmc_pin_model.sv]
// Model of the external count, gate, interrupt and low-frequency clock pins.
// Assumes the block samples the pins on the rising core clock.
`timescale 1ns/1ps
module tmc_pin_model (
	input  wire logic          core_clk,
	output tmc_pkg::tmc_pins_t pins
);
	import tmc_pkg::*;

	// Idle levels: inputs high, slow clock low
	initial pins = '{t0: 1'b1, t1: 1'b1, t2: 1'b1, int0: 1'b1, int1: 1'b1, lf_clk: 1'b0};

	task automatic pulse(input int b, input int n, input int h);
		repeat (2 * n) begin
			@(posedge core_clk);
			pins[b] <= ~pins[b];
			repeat (h - 1) @(posedge core_clk);
		end
	endtask

	// Static level change
	task automatic set_pin(input int b, input logic v);
		@(posedge core_clk);
		pins[b] <= v;
	endtask
endmodule

// [tmc_pkg.sv]
// Constants, types and register map of the timer/counter set.
// Assumes one core clock and a plain strobe register port.
// Contract
// - Timer mode: timers 0/1 step every 12 clocks
// - Counter mode: step on own pin falling edge
// - Edge recognition takes two clocks, any duty
// - Mode 0 13-bit, mode 1 16-bit
// - 13-bit mode leaves low-byte top bits alone
// - Mode 2: 8-bit counter with auto reload
// - Mode 3 splits timer 0 into two 8-bit
// - Timer 1 in mode 3 holds its count
// - Timer 1 usable while timer 0 split
// - Mode field codes 00/01/10/11 as listed
// - Select bits 6/2: 1 counter, 0 timer
// - Overflow flags at bits 7 and 5
// - Run bits 6 and 4 gate counting
// - Service entry clears overflow and external flags
// - External flags bits 3/1, type bits 2/0
// - Timer 2 input select codes as listed
// - Timer 2 prescale 12 or 24 by bit 7
// - Event mode: sample, count cycle after fall
// - Gated mode halts timer 2 while input low
// - Reload field codes; mode 0 reloads on overflow
// - Reload mode 1 on trigger falling edge
// - Compare/reload value two bytes, reset zero
package tmc_pkg;
	localparam logic [7:0] ADDR_CTRL_STAT = 8'h88;
	localparam logic [7:0] ADDR_MODE_CFG  = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW    = 8'h8A;
	localparam logic [7:0] ADDR_T1_LOW    = 8'h8B;
	localparam logic [7:0] ADDR_T0_HIGH   = 8'h8C;
	localparam logic [7:0] ADDR_T1_HIGH   = 8'h8D;
	localparam logic [7:0] ADDR_T2_CTRL   = 8'hC8;
	localparam logic [7:0] ADDR_RELOAD_LO = 8'hCA;
	localparam logic [7:0] ADDR_RELOAD_HI = 8'hCB;
	localparam logic [7:0] ADDR_T2_LOW    = 8'hCC;
	localparam logic [7:0] ADDR_T2_HIGH   = 8'hCD;
	// Control/status bit positions
	localparam int CS_TF1 = 7;
	localparam int CS_TR1 = 6;
	localparam int CS_TF0 = 5;
	localparam int CS_TR0 = 4;
	localparam int CS_IE1 = 3;
	localparam int CS_IT1 = 2;
	localparam int CS_IE0 = 1;
	localparam int CS_IT0 = 0;
	// Mode register bit positions
	localparam int MC_CT1   = 6;
	localparam int MC_M1_HI = 5;
	localparam int MC_M1_LO = 4;
	localparam int MC_TIMER0_GATING_BIT = 3;
	localparam int MC_CT0   = 2;
	localparam int MC_M0_HI = 1;
	localparam int MC_M0_LO = 0;
	localparam logic [7:0] MC_WR_MASK = 8'h7F;
	// Timer 2 control bit positions
	localparam int T2_PS    = 7;
	localparam int T2_R_HI  = 4;
	localparam int T2_R_LO  = 3;
	localparam int T2_I_HI  = 1;
	localparam int T2_I_LO  = 0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Pin idle levels: inputs high, slow clock low
	localparam logic [5:0] PIN_IDLE   = 6'h3E;
	// Prescaler counts in core clocks
	localparam int PRESC_FAST = 12;
	localparam int PRESC_SLOW = 24;
	localparam logic [4:0] PRESC_FAST_LAST = 5'(PRESC_FAST - 1);
	localparam logic [4:0] PRESC_SLOW_LAST = 5'(PRESC_SLOW - 1);

	typedef enum logic [1:0] {
		MODE_13    = 2'b00,
		MODE_16    = 2'b01,
		MODE_8R    = 2'b10,
		MODE_SPLIT = 2'b11
	} tmc_mode_t;

	typedef enum logic [1:0] {
		T2_STOP  = 2'b00,
		T2_TIMER = 2'b01,
		T2_EVENT = 2'b10,
		T2_GATED = 2'b11
	} tmc_t2_in_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tmc_bus_t;

	typedef struct packed {
		logic t0;
		logic t1;
		logic t2;
		logic int0;
		logic int1;
		logic lf_clk;
	} tmc_pins_t;

	typedef struct packed {
		logic tf1;
		logic tf0;
		logic ie1;
		logic ie0;
	} tmc_ack_t;

	typedef struct packed {
		logic tf1;
		logic tf0;
		logic ie1;
		logic ie0;
		logic t2_ovf;
	} tmc_irq_t;

	typedef struct packed {
		logic       ovf;
		logic [7:0] hi;
		logic [7:0] lo;
	} tmc_cnt_t;
endpackage

// [tmc_timers.sv]
// Timers 0, 1 and 2 with their register file.
// Assumes pins are asynchronous and acks come from the core clock domain.
`timescale 1ns/1ps
module tmc_timers (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              clk_en,
	input  wire tmc_pkg::tmc_bus_t  bus,
	output logic [7:0]             rd_data,
	input  wire tmc_pkg::tmc_pins_t pins,
	input  wire tmc_pkg::tmc_ack_t  ack,
	output tmc_pkg::tmc_irq_t       irq
);
	import tmc_pkg::*;

	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic [5:0] prev_r;
	logic [4:0] presc_r;
	logic [7:0] tl0_r;
	logic [7:0] th0_r;
	logic [7:0] tl1_r;
	logic [7:0] th1_r;
	logic [7:0] tl2_r;
	logic [7:0] th2_r;
	logic [7:0] crl_r;
	logic [7:0] crh_r;
	logic [7:0] mode_cfg_r;
	logic [7:0] t2ctl_r;
	logic       tr1_r;
	logic       tr0_r;
	logic       it1_r;
	logic       it0_r;
	logic       tf1_r;
	logic       tf0_r;
	logic       ie1_r;
	logic       ie0_r;
	logic       t2_fall_r;
	logic       t2_ovf_r;
	logic       trig_r;
	logic [7:0] rd_data_r;

	logic       tick12;
	logic       tick24;
	logic [5:0] fall;
	tmc_mode_t  timer0_mode_field;
	tmc_mode_t  timer1_mode_field;
	tmc_t2_in_t t2_in;
	logic       t0_split;
	logic       run0;
	logic       run1;
	logic       t0_tick;
	logic       t1_tick;
	logic       th0_tick;
	logic       t2_tick;
	logic       t2_ovf;
	logic       t2_reload;
	logic       lf_rise;
	logic       trig_fall;
	logic       tf1_set;
	logic       tf0_set;
	logic       ie1_set;
	logic       ie0_set;
	logic [7:0] cs_base;
	tmc_cnt_t   t0_nx;
	tmc_cnt_t   t1_nx;

	function automatic logic wr_hit(tmc_bus_t b, logic [7:0] a);
		return b.wr && (b.addr == a);
	endfunction

	function automatic tmc_cnt_t step(tmc_mode_t m, logic [7:0] hi, logic [7:0] lo);
		tmc_cnt_t r;
		r = '{ovf: 1'b0, hi: hi, lo: lo};
		case (m)
			MODE_13: begin
				r.lo = {lo[7:5], lo[4:0] + 5'h01};
				if (lo[4:0] == 5'h1F) begin
					r.hi = hi + 8'h01;
					r.ovf = (hi == 8'hFF);
				end
			end
			MODE_16: begin
				{r.hi, r.lo} = {hi, lo} + 16'h0001;
				r.ovf = &{hi, lo};
			end
			MODE_8R: begin
				if (&lo) begin
					r.lo = hi;
					r.ovf = 1'b1;
				end else begin
					r.lo = lo + 8'h01;
				end
			end
			default: begin
				r.lo = lo + 8'h01;
				r.ovf = &lo;
			end
		endcase
		return r;
	endfunction

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync1_r <= PIN_IDLE;
			sync2_r <= PIN_IDLE;
			prev_r <= PIN_IDLE;
		end else if (clk_en) begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end
	assign fall = prev_r & ~sync2_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			presc_r <= 5'h00;
		end else if (clk_en) begin
			presc_r <= (presc_r == PRESC_SLOW_LAST) ? 5'h00 : presc_r + 5'h01;
		end
	end
	assign tick24 = (presc_r == PRESC_SLOW_LAST);
	assign tick12 = tick24 || (presc_r == PRESC_FAST_LAST);

	assign timer0_mode_field = tmc_mode_t'(mode_cfg_r[MC_M0_HI:MC_M0_LO]);
	assign timer1_mode_field = tmc_mode_t'(mode_cfg_r[MC_M1_HI:MC_M1_LO]);
	assign t0_split = (timer0_mode_field == MODE_SPLIT);
	assign run0 = tr0_r && (!mode_cfg_r[MC_TIMER0_GATING_BIT] || sync2_r[2]);
	assign run1 = t0_split || tr1_r;
	assign t0_tick = run0 && (mode_cfg_r[MC_CT0] ? fall[5] : tick12);
	assign t1_tick = run1 && (timer1_mode_field != MODE_SPLIT) && (mode_cfg_r[MC_CT1] ? fall[4] : tick12);
	assign th0_tick = t0_split && tr1_r && tick12;
	assign t0_nx = step(timer0_mode_field, th0_r, tl0_r);
	assign t1_nx = step(timer1_mode_field, th1_r, tl1_r);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tl0_r <= RESET_BYTE;
			th0_r <= RESET_BYTE;
		end else if (clk_en) begin
			if (wr_hit(bus, ADDR_T0_LOW)) begin
				tl0_r <= bus.wdata;
			end else if (t0_tick) begin
				tl0_r <= t0_nx.lo;
			end
			if (wr_hit(bus, ADDR_T0_HIGH)) begin
				th0_r <= bus.wdata;
			end else if (th0_tick) begin
				th0_r <= th0_r + 8'h01;
			end else if (t0_tick && !t0_split) begin
				th0_r <= t0_nx.hi;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tl1_r <= RESET_BYTE;
			th1_r <= RESET_BYTE;
		end else if (clk_en) begin
			if (wr_hit(bus, ADDR_T1_LOW)) begin
				tl1_r <= bus.wdata;
			end else if (t1_tick) begin
				tl1_r <= t1_nx.lo;
			end
			if (wr_hit(bus, ADDR_T1_HIGH)) begin
				th1_r <= bus.wdata;
			end else if (t1_tick) begin
				th1_r <= t1_nx.hi;
			end
		end
	end

	assign tf0_set = t0_tick && t0_nx.ovf;
	assign tf1_set = (th0_tick && (th0_r == 8'hFF)) || (!t0_split && t1_tick && t1_nx.ovf);
	assign ie0_set = it0_r ? fall[2] : !sync2_r[2];
	assign ie1_set = it1_r ? fall[1] : !sync2_r[1];
	assign cs_base = wr_hit(bus, ADDR_CTRL_STAT) ? bus.wdata
		: {tf1_r, tr1_r, tf0_r, tr0_r, ie1_r, it1_r, ie0_r, it0_r};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tf1_r <= 1'b0;
			tf0_r <= 1'b0;
			ie1_r <= 1'b0;
			ie0_r <= 1'b0;
		end else if (clk_en) begin
			tf1_r <= tf1_set || (cs_base[CS_TF1] && !ack.tf1);
			tf0_r <= tf0_set || (cs_base[CS_TF0] && !ack.tf0);
			ie1_r <= ie1_set || (cs_base[CS_IE1] && !ack.ie1);
			ie0_r <= ie0_set || (cs_base[CS_IE0] && !ack.ie0);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tr1_r <= 1'b0;
			tr0_r <= 1'b0;
			it1_r <= 1'b0;
			it0_r <= 1'b0;
		end else if (clk_en && wr_hit(bus, ADDR_CTRL_STAT)) begin
			tr1_r <= bus.wdata[CS_TR1];
			tr0_r <= bus.wdata[CS_TR0];
			it1_r <= bus.wdata[CS_IT1];
			it0_r <= bus.wdata[CS_IT0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_cfg_r <= RESET_BYTE;
			t2ctl_r <= RESET_BYTE;
		end else if (clk_en) begin
			if (wr_hit(bus, ADDR_MODE_CFG)) begin
				mode_cfg_r <= bus.wdata & MC_WR_MASK;
			end
			if (wr_hit(bus, ADDR_T2_CTRL)) begin
				t2ctl_r <= bus.wdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			crl_r <= RESET_BYTE;
			crh_r <= RESET_BYTE;
		end else if (clk_en) begin
			if (wr_hit(bus, ADDR_RELOAD_LO)) begin
				crl_r <= bus.wdata;
			end
			if (wr_hit(bus, ADDR_RELOAD_HI)) begin
				crh_r <= bus.wdata;
			end
		end
	end

	assign lf_rise = sync2_r[0] && !prev_r[0];
	assign trig_fall = lf_rise && trig_r;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			trig_r <= 1'b0;
			t2_fall_r <= 1'b0;
		end else if (clk_en) begin
			trig_r <= trig_r ^ lf_rise;
			t2_fall_r <= fall[3];
		end
	end

	assign t2_in = tmc_t2_in_t'(t2ctl_r[T2_I_HI:T2_I_LO]);
	always_comb begin
		case (t2_in)
			T2_TIMER: t2_tick = t2ctl_r[T2_PS] ? tick24 : tick12;
			T2_EVENT: t2_tick = t2_fall_r;
			T2_GATED: t2_tick = (t2ctl_r[T2_PS] ? tick24 : tick12) && sync2_r[3];
			default:  t2_tick = 1'b0;
		endcase
	end
	assign t2_ovf = t2_tick && (&{th2_r, tl2_r});
	assign t2_reload = t2ctl_r[T2_R_HI] && (t2ctl_r[T2_R_LO] ? trig_fall : t2_ovf);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tl2_r <= RESET_BYTE;
			th2_r <= RESET_BYTE;
			t2_ovf_r <= 1'b0;
		end else if (clk_en) begin
			t2_ovf_r <= t2_ovf;
			if (wr_hit(bus, ADDR_T2_LOW)) begin
				tl2_r <= bus.wdata;
			end else if (t2_reload) begin
				tl2_r <= crl_r;
			end else if (t2_tick) begin
				tl2_r <= tl2_r + 8'h01;
			end
			if (wr_hit(bus, ADDR_T2_HIGH)) begin
				th2_r <= bus.wdata;
			end else if (t2_reload) begin
				th2_r <= crh_r;
			end else if (t2_tick && (&tl2_r)) begin
				th2_r <= th2_r + 8'h01;
			end
		end
	end

	// Read port, data valid one cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_data_r <= 8'h00;
		end else if (clk_en) begin
			rd_data_r <= 8'h00;
			if (bus.rd) begin
				case (bus.addr)
					ADDR_CTRL_STAT: rd_data_r <= {tf1_r, tr1_r, tf0_r, tr0_r,
						ie1_r, it1_r, ie0_r, it0_r};
					ADDR_MODE_CFG:  rd_data_r <= mode_cfg_r;
					ADDR_T0_LOW:    rd_data_r <= tl0_r;
					ADDR_T0_HIGH:   rd_data_r <= th0_r;
					ADDR_T1_LOW:    rd_data_r <= tl1_r;
					ADDR_T1_HIGH:   rd_data_r <= th1_r;
					ADDR_T2_CTRL:   rd_data_r <= t2ctl_r;
					ADDR_RELOAD_LO: rd_data_r <= crl_r;
					ADDR_RELOAD_HI: rd_data_r <= crh_r;
					ADDR_T2_LOW:    rd_data_r <= tl2_r;
					ADDR_T2_HIGH:   rd_data_r <= th2_r;
					default:        rd_data_r <= 8'h00;
				endcase
			end
		end
	end

	assign rd_data = rd_data_r;
	assign irq = '{tf1: tf1_r, tf0: tf0_r, ie1: ie1_r, ie0: ie0_r, t2_ovf: t2_ovf_r};

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst || !clk_en);

	property p_tick12_period;
		tick12 |=> (!tick12) [*8] ##1 (!tick12) [*3] ##1 tick12;
	endproperty
	a_tick12_period: assert property (p_tick12_period) else $error("prescale period wrong");

	property p_t0_count16;
		(t0_tick && timer0_mode_field == MODE_16 && !wr_hit(bus, ADDR_T0_LOW) && !wr_hit(bus, ADDR_T0_HIGH))
			|=> {th0_r, tl0_r} == $past({th0_r, tl0_r}) + 16'h0001;
	endproperty
	a_t0_count16: assert property (p_t0_count16) else $error("timer 0 16-bit step wrong");

	property p_t0_pin_count;
		(tr0_r && !mode_cfg_r[MC_TIMER0_GATING_BIT] && mode_cfg_r[MC_CT0] && timer0_mode_field == MODE_16
			&& $fell(sync2_r[5]) && !wr_hit(bus, ADDR_T0_LOW) && !wr_hit(bus, ADDR_T0_HIGH))
			|=> tl0_r != $past(tl0_r);
	endproperty
	a_t0_pin_count: assert property (p_t0_pin_count) else $error("timer 0 missed pin edge");

	property p_mode13_top;
		(timer0_mode_field == MODE_13 && !wr_hit(bus, ADDR_T0_LOW)) |=> tl0_r[7:5] == $past(tl0_r[7:5]);
	endproperty
	a_mode13_top: assert property (p_mode13_top) else $error("low byte top bits changed");

	property p_mode2_reload;
		(t0_tick && timer0_mode_field == MODE_8R && tl0_r == 8'hFF && !wr_hit(bus, ADDR_T0_LOW))
			|=> tl0_r == $past(th0_r) && tf0_r;
	endproperty
	a_mode2_reload: assert property (p_mode2_reload) else $error("auto reload wrong");

	property p_t1_hold;
		(timer1_mode_field == MODE_SPLIT && !wr_hit(bus, ADDR_T1_LOW) && !wr_hit(bus, ADDR_T1_HIGH))
			|=> $stable({th1_r, tl1_r});
	endproperty
	a_t1_hold: assert property (p_t1_hold) else $error("timer 1 moved in mode 3");

	property p_ack_clear;
		(ack.tf1 && !tf1_set && !wr_hit(bus, ADDR_CTRL_STAT)) |=> !tf1_r;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("service clear failed");

	property p_gated_halt;
		(t2_in == T2_GATED && !sync2_r[3] && !t2_reload && !wr_hit(bus, ADDR_T2_LOW)
			&& !wr_hit(bus, ADDR_T2_HIGH)) |=> $stable({th2_r, tl2_r});
	endproperty
	a_gated_halt: assert property (p_gated_halt) else $error("gated timer 2 moved");

	property p_t2_reload0;
		(t2_ovf && t2ctl_r[T2_R_HI:T2_R_LO] == 2'b10 && !wr_hit(bus, ADDR_T2_LOW)
			&& !wr_hit(bus, ADDR_T2_HIGH)) |=> {th2_r, tl2_r} == $past({crh_r, crl_r});
	endproperty
	a_t2_reload0: assert property (p_t2_reload0) else $error("overflow reload wrong");

	property p_t2_event;
		(fall[3] && t2_in == T2_EVENT && t2ctl_r[T2_R_HI] == 1'b0) ##1
			(!wr_hit(bus, ADDR_T2_LOW) && !wr_hit(bus, ADDR_T2_HIGH) && t2_in == T2_EVENT)
			|=> {th2_r, tl2_r} == $past({th2_r, tl2_r}) + 16'h0001;
	endproperty
	a_t2_event: assert property (p_t2_event) else $error("event count late or lost");

	c_t0_overflow: cover property (tf0_set);
	c_split_high: cover property (th0_tick && th0_r == 8'hFF);
	c_t2_trigger_reload: cover property (t2_reload && t2ctl_r[T2_R_LO]);
endmodule

// [tmc_timers_tb.sv]
// Self-checking bench for the timer/counter set.
// Assumes the pin model drives the pins and the bench owns bus and acks.
`timescale 1ns/1ps
module tmc_timers_tb;
	import tmc_pkg::*;
	localparam int T0P = 5, T1P = 4, T2P = 3, I0P = 2, I1P = 1, LFP = 0;
	localparam int F1 = 4, F0 = 3, E1 = 2, E0 = 1, OV = 0;
	logic       core_clk  = 1'b0;
	logic       rst       = 1'b1;
	tmc_bus_t   bus       = '0;
	tmc_ack_t   ack       = '0;
	tmc_pins_t  pins;
	logic [7:0] rd_data;
	tmc_irq_t   irq;
	logic [7:0] v;
	int         cyc       = 0;
	int         bad_count = 0;
	int         tests_run = 0;

	always #50 core_clk = ~core_clk;

	tmc_timers tmc_timers_inst (
		.core_clk(core_clk),
		.rst     (rst),
		.clk_en  (1'b1),
		.bus     (bus),
		.rd_data (rd_data),
		.pins    (pins),
		.ack     (ack),
		.irq     (irq)
	);

	tmc_pin_model tmc_pin_model_inst (
		.core_clk(core_clk),
		.pins    (pins)
	);

	// Cycle count and hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge core_clk);
		bus.rd <= 1'b0;
		@(negedge core_clk);
		chk(nm, rd_data, e);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic clr(input int b);
		@(posedge core_clk);
		ack[b - 1] <= 1'b1;
		@(posedge core_clk);
		ack <= '0;
	endtask

	task automatic see(input int b, input int lim, output int t);
		t = -1;
		for (int i = 0; i < lim && t < 0; i++) begin
			@(negedge core_clk);
			if (irq[b] === 1'b1)
				t = cyc;
		end
	endtask

	task automatic hit(input string nm, input int b, input int lim, input logic e);
		int t;
		see(b, lim, t);
		chk(nm, {7'h00, t >= 0}, {7'h00, e});
	endtask

	task automatic period(input string nm, input int b, input int p);
		int a;
		int c;
		see(b, 40, a);
		if (b > 0)
			clr(b);
		see(b, 40, c);
		chk(nm, 8'(c - a), 8'(p));
	endtask

	task automatic t_regs();
		rdchk("ctrl", ADDR_CTRL_STAT, 8'h00);
		rdchk("mode", ADDR_MODE_CFG, 8'h00);
		rdchk("t2ctl", ADDR_T2_CTRL, 8'h00);
		rdchk("rld_lo", ADDR_RELOAD_LO, 8'h00);
		rdchk("rld_hi", ADDR_RELOAD_HI, 8'h00);
		wr(8'h80, 8'h5A);
		rdchk("unmapped", 8'h80, 8'h00);
		wr(ADDR_MODE_CFG, 8'hFF);
		rdchk("mode_rsv", ADDR_MODE_CFG, 8'h7F);
		$display("done regs");
	endtask

	task automatic t_t0tmr();
		wr(ADDR_MODE_CFG, 8'h02);
		wr(ADDR_T0_HIGH, 8'hFF);
		wr(ADDR_T0_LOW, 8'hFF);
		wr(ADDR_CTRL_STAT, 8'h10);
		period("t0_tick", F0, 12);
		rdchk("tf0_bit", ADDR_CTRL_STAT, 8'h30);
		wr(ADDR_CTRL_STAT, 8'h00);
		wr(ADDR_MODE_CFG, 8'h01);
		wr(ADDR_T0_LOW, 8'h00);
		idle(30);
		rdchk("t0_stop", ADDR_T0_LOW, 8'h00);
		$display("done timer0 timer");
	endtask

	task automatic t_cnt();
		wr(ADDR_MODE_CFG, 8'h05);
		wr(ADDR_T0_HIGH, 8'h00);
		wr(ADDR_T0_LOW, 8'hFF);
		wr(ADDR_CTRL_STAT, 8'h10);
		tmc_pin_model_inst.pulse(T0P, 1, 2);
		idle(4);
		rdchk("m1_lo", ADDR_T0_LOW, 8'h00);
		rdchk("m1_hi", ADDR_T0_HIGH, 8'h01);
		wr(ADDR_MODE_CFG, 8'h04);
		wr(ADDR_T0_LOW, 8'hBF);
		wr(ADDR_T0_HIGH, 8'h00);
		tmc_pin_model_inst.pulse(T0P, 1, 2);
		idle(4);
		rdchk("m0_lo", ADDR_T0_LOW, 8'hA0);
		rdchk("m0_hi", ADDR_T0_HIGH, 8'h01);
		wr(ADDR_MODE_CFG, 8'h05);
		wr(ADDR_T0_LOW, 8'h00);
		tmc_pin_model_inst.pulse(T0P, 10, 1);
		idle(4);
		rdchk("fast", ADDR_T0_LOW, 8'h0A);
		$display("done timer0 counter");
	endtask

	task automatic t_t1();
		wr(ADDR_MODE_CFG, 8'h70);
		wr(ADDR_T1_LOW, 8'h55);
		wr(ADDR_CTRL_STAT, 8'h40);
		tmc_pin_model_inst.pulse(T1P, 3, 2);
		idle(4);
		rdchk("t1_hold", ADDR_T1_LOW, 8'h55);
		wr(ADDR_MODE_CFG, 8'h50);
		tmc_pin_model_inst.pulse(T1P, 3, 2);
		idle(4);
		rdchk("t1_cnt", ADDR_T1_LOW, 8'h58);
		wr(ADDR_MODE_CFG, 8'h53);
		wr(ADDR_T1_LOW, 8'h10);
		wr(ADDR_T0_HIGH, 8'hFF);
		wr(ADDR_CTRL_STAT, 8'h40);
		hit("split_tf1", F1, 30, 1'b1);
		tmc_pin_model_inst.pulse(T1P, 2, 2);
		idle(4);
		rdchk("t1_free", ADDR_T1_LOW, 8'h12);
		$display("done timer1 and split");
	endtask

	task automatic t_gate();
		wr(ADDR_CTRL_STAT, 8'h01);
		wr(ADDR_MODE_CFG, 8'h0A);
		wr(ADDR_T0_HIGH, 8'hFF);
		wr(ADDR_T0_LOW, 8'hFF);
		tmc_pin_model_inst.set_pin(I0P, 1'b0);
		hit("ie0_edge", E0, 10, 1'b1);
		wr(ADDR_CTRL_STAT, 8'h13);
		hit("gated_off", F0, 40, 1'b0);
		clr(E0);
		rdchk("ie0_ack", ADDR_CTRL_STAT, 8'h11);
		tmc_pin_model_inst.set_pin(I0P, 1'b1);
		hit("gated_on", F0, 30, 1'b1);
		wr(ADDR_CTRL_STAT, 8'h00);
		tmc_pin_model_inst.set_pin(I1P, 1'b0);
		hit("ie1_lvl", E1, 10, 1'b1);
		clr(E1);
		hit("ie1_again", E1, 10, 1'b1);
		tmc_pin_model_inst.set_pin(I1P, 1'b1);
		idle(4);
		wr(ADDR_CTRL_STAT, 8'h00);
		$display("done gate and ext flags");
	endtask

	task automatic t_t2();
		wr(ADDR_RELOAD_LO, 8'hFF);
		wr(ADDR_RELOAD_HI, 8'hFF);
		wr(ADDR_T2_LOW, 8'hFF);
		wr(ADDR_T2_HIGH, 8'hFF);
		wr(ADDR_T2_CTRL, 8'h11);
		period("t2_12", OV, 12);
		wr(ADDR_T2_CTRL, 8'h91);
		period("t2_24", OV, 24);
		wr(ADDR_T2_CTRL, 8'h02);
		wr(ADDR_T2_LOW, 8'h00);
		tmc_pin_model_inst.pulse(T2P, 4, 1);
		idle(5);
		rdchk("t2_evt", ADDR_T2_LOW, 8'h04);
		tmc_pin_model_inst.set_pin(T2P, 1'b0);
		idle(4);
		wr(ADDR_T2_LOW, 8'hFF);
		wr(ADDR_T2_HIGH, 8'hFF);
		wr(ADDR_T2_CTRL, 8'h13);
		hit("gate_low", OV, 40, 1'b0);
		tmc_pin_model_inst.set_pin(T2P, 1'b1);
		hit("gate_high", OV, 40, 1'b1);
		wr(ADDR_T2_CTRL, 8'h10);
		hit("t2_stop", OV, 40, 1'b0);
		wr(ADDR_RELOAD_LO, 8'h34);
		wr(ADDR_RELOAD_HI, 8'h12);
		wr(ADDR_T2_LOW, 8'h00);
		wr(ADDR_T2_HIGH, 8'h00);
		wr(ADDR_T2_CTRL, 8'h18);
		tmc_pin_model_inst.pulse(LFP, 2, 3);
		idle(5);
		rdchk("rl1_lo", ADDR_T2_LOW, 8'h34);
		rdchk("rl1_hi", ADDR_T2_HIGH, 8'h12);
		$display("done timer2");
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_t0tmr();
		t_cnt();
		t_t1();
		t_gate();
		t_t2();
		wrap_up();
	end
endmodule
